// >>> rtl/bal_adder8.sv
`timescale 1ns/10ps
`default_nettype none

module bal_adder8 (
    // Operands
    input wire logic [7:0] a,
    input wire logic [7:0] b,
    input wire logic carry_in,
    // Result
    output logic [7:0] sum,
    output logic carry_out,
    output logic nibble_carry
);

    logic [4:0] low_sum;
    logic [4:0] high_sum;

    // Split at the nibble so the bit-3 carry is visible
    assign low_sum = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, carry_in};
    assign high_sum = {1'b0, a[7:4]} + {1'b0, b[7:4]} + {4'h0, low_sum[4]};
    assign sum = {high_sum[3:0], low_sum[3:0]};
    assign carry_out = high_sum[4];
    assign nibble_carry = low_sum[4];

endmodule // bal_adder8

`default_nettype wire

// >>> rtl/bal_alu.sv
`timescale 1ns/10ps
`default_nettype none

module bal_alu #(
    parameter int FILE_DEPTH = bal_pkg::BAL_FILE_DEPTH
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Decoded instruction
    input wire logic instr_valid,
    input wire logic [3:0] instr_op,
    input wire logic [6:0] instr_reg_idx,
    input wire logic [7:0] instr_literal,
    input wire logic instr_dest,
    input wire logic [2:0] instr_bit,
    input wire logic instr_ptr_sel,
    // Architectural state
    output logic [7:0] acc_out,
    output logic carry_out,
    output logic nibble_overflow_bit,
    output logic zero_out,
    output logic [15:0] ptr0_out,
    output logic [15:0] ptr1_out,
    // Avalon-MM slave
    input wire logic [9:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest
);

    if (FILE_DEPTH < 1 || FILE_DEPTH > bal_pkg::BAL_FILE_DEPTH) begin : g_bad
        $error("bal_alu: FILE_DEPTH must be 1..128");
    end

    ////////////////////////////////////////////////////////////////////////
    // State
    logic [7:0] acc_reg;
    logic [2:0] status_reg;
    logic [15:0] ptr_reg [2];
    logic [7:0] file_reg [FILE_DEPTH];
    logic rd_done_reg;
    logic [31:0] rdata_reg;

    ////////////////////////////////////////////////////////////////////////
    // Decode
    wire is_ptr = instr_op == bal_pkg::BAL_OP_POINTER_LITERAL_ADD;
    wire is_andl = instr_op == bal_pkg::BAL_OP_MASK_IMMEDIATE;
    wire is_addl = instr_op == bal_pkg::BAL_OP_SUM_IMMEDIATE;
    wire is_andf = instr_op == bal_pkg::BAL_OP_MASK_WITH_REGISTER;
    wire is_addf = instr_op == bal_pkg::BAL_OP_SUM_WITH_REGISTER;
    wire is_addc = instr_op == bal_pkg::BAL_OP_SUM_WITH_REGISTER_CARRY;
    wire is_shr = instr_op == bal_pkg::BAL_OP_SIGNED_SHIFT_RIGHT;
    wire is_clr = instr_op == bal_pkg::BAL_OP_CLEAR_BIT_IN_REGISTER;
    wire reg_op = is_andf | is_addf | is_addc | is_shr;
    wire add_op = is_addl | is_addf | is_addc;
    wire flag_op = add_op | is_andl | is_andf | is_shr;

    // Out-of-range indices read as zero and are not written
    wire idx_ok = 32'(instr_reg_idx) < FILE_DEPTH;
    wire [7:0] fval = idx_ok ? file_reg[instr_reg_idx] : 8'h00;

    ////////////////////////////////////////////////////////////////////////
    // Datapath
    wire [7:0] add_b = is_addl ? instr_literal : fval;
    wire add_cin = is_addc & status_reg[bal_pkg::BAL_ST_CARRY];
    wire [7:0] add_sum;
    wire add_c;
    wire add_nib;

    bal_adder8 u_adder (
        .a(acc_reg),
        .b(add_b),
        .carry_in(add_cin),
        .sum(add_sum),
        .carry_out(add_c),
        .nibble_carry(add_nib)
    );

    wire [7:0] and_b = is_andl ? instr_literal : fval;
    wire [7:0] and_res = acc_reg & and_b;
    wire [7:0] shr_res = {fval[7], fval[7:1]};
    wire [7:0] clr_res = fval & ~(8'h01 << instr_bit);

    wire [7:0] alu_res = add_op ? add_sum :
                         (is_andl | is_andf) ? and_res :
                         is_shr ? shr_res : clr_res;

    // Accumulator or file destination
    wire wr_acc = instr_valid &
        (is_andl | is_addl | (reg_op & ~instr_dest));
    wire wr_file = instr_valid & idx_ok &
        ((reg_op & instr_dest) | is_clr);

    wire new_zero = alu_res == 8'h00;
    wire new_carry = is_shr ? fval[0] : (add_op ? add_c :
        status_reg[bal_pkg::BAL_ST_CARRY]);
    wire new_nib = add_op ? add_nib : status_reg[bal_pkg::BAL_ST_NIBBLE];
    wire [2:0] flags_calc = {new_zero, new_nib, new_carry};

    // Sign-extended literal; 16-bit sum drops the carry, giving wrap
    wire [15:0] ptr_lit =
        {{10{instr_literal[5]}}, instr_literal[5:0]};
    wire [15:0] ptr_sum = ptr_reg[instr_ptr_sel] + ptr_lit;

    ////////////////////////////////////////////////////////////////////////
    // Bus decode
    // Bus writes wait while an instruction executes, so the two never collide
    wire bus_wr = avs_write & ~instr_valid;
    wire in_file = avs_address[bal_pkg::BAL_FILE_WIN_BIT];
    wire [6:0] bus_idx = avs_address[8:2];
    wire bus_idx_ok = 32'(bus_idx) < FILE_DEPTH;
    wire sel_acc = ~in_file & avs_address == bal_pkg::BAL_OFF_ACC;
    wire sel_st = ~in_file & avs_address == bal_pkg::BAL_OFF_STATUS;
    wire sel_p0 = ~in_file & avs_address == bal_pkg::BAL_OFF_PTR0;
    wire sel_p1 = ~in_file & avs_address == bal_pkg::BAL_OFF_PTR1;
    wire sel_file = in_file & bus_idx_ok & avs_address[1:0] == 2'b00;
    wire be0 = avs_byteenable[0];
    wire be1 = avs_byteenable[1];

    wire [31:0] rd_mux = sel_acc ? {24'h0, acc_reg} :
                         sel_st ? {29'h0, status_reg} :
                         sel_p0 ? {16'h0, ptr_reg[0]} :
                         sel_p1 ? {16'h0, ptr_reg[1]} :
                         sel_file ? {24'h0, file_reg[bus_idx]} : 32'h0;

    assign avs_waitrequest = (avs_read & ~rd_done_reg) |
                             (avs_write & instr_valid);
    assign avs_readdata = rdata_reg;

    ////////////////////////////////////////////////////////////////////////
    // Next values
    wire [7:0] acc_next = wr_acc ? alu_res :
        (bus_wr & sel_acc & be0) ? avs_writedata[7:0] : acc_reg;
    wire [2:0] status_next = (instr_valid & flag_op) ?
        {new_zero, is_andl | is_andf ? status_reg[1:0] : flags_calc[1:0]} :
        (bus_wr & sel_st & be0) ? avs_writedata[2:0] : status_reg;

    wire [15:0] bus_ptr = {be1 ? avs_writedata[15:8] : 8'h00,
                           be0 ? avs_writedata[7:0] : 8'h00};

    ////////////////////////////////////////////////////////////////////////
    // Registers
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            acc_reg <= bal_pkg::BAL_ACC_RST;
            status_reg <= bal_pkg::BAL_STATUS_RST;
        end else begin
            acc_reg <= acc_next;
            status_reg <= status_next;
        end
    end

    for (genvar p = 0; p < 2; p++) begin : g_ptr
        wire hit_i = instr_valid & is_ptr & (instr_ptr_sel == 1'(p));
        wire hit_b = bus_wr & (p == 0 ? sel_p0 : sel_p1);
        wire [15:0] masked = {be1 ? bus_ptr[15:8] : ptr_reg[p][15:8],
                              be0 ? bus_ptr[7:0] : ptr_reg[p][7:0]};
        always_ff @(posedge ref_clk) begin
            if (!rst_n) begin
                ptr_reg[p] <= bal_pkg::BAL_PTR_RST;
            end else if (hit_i) begin
                ptr_reg[p] <= ptr_sum;
            end else if (hit_b) begin
                ptr_reg[p] <= masked;
            end
        end
    end

    for (genvar i = 0; i < FILE_DEPTH; i++) begin : g_file
        wire hit_i = wr_file & (32'(instr_reg_idx) == i);
        wire hit_b = bus_wr & sel_file & be0 & (32'(bus_idx) == i);
        always_ff @(posedge ref_clk) begin
            if (!rst_n) begin
                file_reg[i] <= bal_pkg::BAL_FILE_RST;
            end else if (hit_i) begin
                file_reg[i] <= alu_res;
            end else if (hit_b) begin
                file_reg[i] <= avs_writedata[7:0];
            end
        end
    end

    // Read answers one cycle after the request, from a flop
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            rd_done_reg <= 1'b0;
            rdata_reg <= 32'h0;
        end else begin
            rd_done_reg <= avs_read & ~rd_done_reg;
            if (avs_read & ~rd_done_reg) begin
                rdata_reg <= rd_mux;
            end
        end
    end

    assign acc_out = acc_reg;
    assign carry_out = status_reg[bal_pkg::BAL_ST_CARRY];
    assign nibble_overflow_bit = status_reg[bal_pkg::BAL_ST_NIBBLE];
    assign zero_out = status_reg[bal_pkg::BAL_ST_ZERO];
    assign ptr0_out = ptr_reg[0];
    assign ptr1_out = ptr_reg[1];

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    wire go = instr_valid & idx_ok;
    wire [8:0] ref_sum = {1'b0, acc_reg} + {1'b0, add_b} + {8'h0, add_cin};

    ptr_flags_hold_a: assert property (instr_valid & is_ptr |=>
        $stable(status_reg) && $stable(acc_reg))
        else $error("pointer add changed flags or accumulator");

    ptr_wrap_a: assert property (
        instr_valid & is_ptr & ~instr_ptr_sel |=>
        ptr_reg[0] == $past(ptr_reg[0]) + {{10{$past(instr_literal[5])}},
        $past(instr_literal[5:0])})
        else $error("pointer 0 sum wrong");

    mask_imm_a: assert property (instr_valid & is_andl |=>
        acc_reg == ($past(acc_reg) & $past(instr_literal)) &&
        status_reg[1:0] == $past(status_reg[1:0]))
        else $error("mask immediate wrong");

    sum_imm_a: assert property (instr_valid & is_addl |=>
        {status_reg[0], acc_reg} == $past(ref_sum))
        else $error("sum immediate wrong");

    mask_reg_a: assert property (go & is_andf & ~instr_dest |=>
        acc_reg == ($past(acc_reg) & $past(fval)))
        else $error("mask with register wrong");

    dest_route_a: assert property (go & reg_op & instr_dest |=>
        $stable(acc_reg) && file_reg[$past(instr_reg_idx)] == $past(alu_res))
        else $error("file destination not honoured");

    sum_reg_a: assert property (go & is_addf & instr_dest |=>
        {status_reg[0], file_reg[$past(instr_reg_idx)]} == $past(ref_sum))
        else $error("sum with register wrong");

    sum_carry_a: assert property (go & is_addc & ~instr_dest |=>
        {status_reg[0], acc_reg} == $past(ref_sum))
        else $error("sum with carry wrong");

    shift_carry_a: assert property (go & is_shr & ~instr_dest |=>
        status_reg[0] == $past(fval[0]) && acc_reg[6:0] == $past(fval[7:1]))
        else $error("shift low bits or carry wrong");

    shift_sign_a: assert property (go & is_shr & ~instr_dest |=>
        acc_reg[7] == $past(fval[7]) && status_reg[1] == $past(status_reg[1]))
        else $error("shift sign or nibble flag wrong");

    clear_bit_a: assert property (go & is_clr |=>
        file_reg[$past(instr_reg_idx)] == ($past(fval) &
        ~(8'h01 << $past(instr_bit))) && $stable(status_reg))
        else $error("clear bit wrong");

    zero_nibble_a: assert property (instr_valid & add_op |=>
        status_reg[2] == ($past(add_sum) == 8'h00) &&
        status_reg[1] == $past(add_nib))
        else $error("zero or nibble flag wrong");

    ptr_other_hold_a: assert property (
        instr_valid & is_ptr & ~instr_ptr_sel |=> $stable(ptr_reg[1]))
        else $error("pointer 1 moved on a pointer 0 add");

    ptr1_wrap_a: assert property (
        instr_valid & is_ptr & instr_ptr_sel |=>
        ptr_reg[1] == $past(ptr_reg[1]) + {{10{$past(instr_literal[5])}},
        $past(instr_literal[5:0])} && $stable(ptr_reg[0]))
        else $error("pointer 1 sum wrong");

    mask_zero_a: assert property (
        instr_valid & (is_andl | is_andf) |=> status_reg[2] ==
        (($past(acc_reg) & $past(and_b)) == 8'h00))
        else $error("mask zero flag wrong");

    mask_keep_a: assert property (go & is_andf |=>
        status_reg[1:0] == $past(status_reg[1:0]))
        else $error("mask with register touched carry or nibble");

    carry_file_a: assert property (go & is_addc & instr_dest |=>
        {status_reg[0], file_reg[$past(instr_reg_idx)]} == $past(ref_sum) &&
        $stable(acc_reg))
        else $error("sum with carry to file wrong");

    shift_zero_a: assert property (go & is_shr |=>
        status_reg[2] == ($past(fval[7:1]) == 7'h00))
        else $error("shift zero flag wrong");

endmodule // bal_alu

`default_nettype wire

// >>> rtl/bal_pkg.sv
package bal_pkg;

    // Decoded operation codes from the fetch/decode stage
    typedef enum logic [3:0] {
        BAL_OP_NOP = 4'h0,
        BAL_OP_POINTER_LITERAL_ADD = 4'h1,
        BAL_OP_MASK_IMMEDIATE = 4'h2,
        BAL_OP_SUM_IMMEDIATE = 4'h3,
        BAL_OP_MASK_WITH_REGISTER = 4'h4,
        BAL_OP_SUM_WITH_REGISTER = 4'h5,
        BAL_OP_SUM_WITH_REGISTER_CARRY = 4'h6,
        BAL_OP_SIGNED_SHIFT_RIGHT = 4'h7,
        BAL_OP_CLEAR_BIT_IN_REGISTER = 4'h8
    } bal_op_t;

    localparam int BAL_DATA_W = 8;
    localparam int BAL_PTR_W = 16;
    localparam int BAL_LIT_PTR_W = 6;
    localparam int BAL_FILE_DEPTH = 128;
    localparam int BAL_IDX_W = 7;
    localparam int BAL_ADDR_W = 10;

    // Register map, byte addresses
    localparam logic [9:0] BAL_OFF_ACC = 10'h000;
    localparam logic [9:0] BAL_OFF_STATUS = 10'h004;
    localparam logic [9:0] BAL_OFF_PTR0 = 10'h008;
    localparam logic [9:0] BAL_OFF_PTR1 = 10'h00c;
    // File registers: base + 4 * index
    localparam int BAL_FILE_WIN_BIT = 9;

    // Status field positions
    localparam int BAL_ST_CARRY = 0;
    localparam int BAL_ST_NIBBLE = 1;
    localparam int BAL_ST_ZERO = 2;

    // Reset values
    localparam logic [7:0] BAL_ACC_RST = 8'h00;
    localparam logic [2:0] BAL_STATUS_RST = 3'h0;
    localparam logic [15:0] BAL_PTR_RST = 16'h0000;
    localparam logic [7:0] BAL_FILE_RST = 8'h00;

endpackage

// >>> tb/bal_decode_model.sv
`timescale 1ns/10ps
`default_nettype none

module bal_decode_model (
    // Clock
    input wire logic ref_clk,
    // Decoded instruction
    output logic instr_valid,
    output logic [3:0] instr_op,
    output logic [6:0] instr_reg_idx,
    output logic [7:0] instr_literal,
    output logic instr_dest,
    output logic [2:0] instr_bit,
    output logic instr_ptr_sel
);
    initial begin
        instr_valid = 1'b0;
        instr_op = 4'h0;
        instr_reg_idx = 7'h00;
        instr_literal = 8'h00;
        instr_dest = 1'b0;
        instr_bit = 3'h0;
        instr_ptr_sel = 1'b0;
    end

    // One op for one cycle; fields are scrambled once it is taken so a
    // block that reads them while idle is caught
    task automatic issue(input logic [3:0] op, input logic [6:0] idx,
                         input logic [7:0] lit, input logic dest,
                         input logic [2:0] b, input logic sel);
        @(posedge ref_clk);
        instr_valid <= 1'b1;
        instr_op <= op;
        instr_reg_idx <= idx;
        instr_literal <= lit;
        instr_dest <= dest;
        instr_bit <= b;
        instr_ptr_sel <= sel;
        @(posedge ref_clk);
        instr_valid <= 1'b0;
        instr_op <= 4'h0;
        instr_reg_idx <= ~idx;
        instr_literal <= ~lit;
        instr_dest <= ~dest;
        instr_bit <= ~b;
        instr_ptr_sel <= ~sel;
        #1;
    endtask
endmodule // bal_decode_model

`default_nettype wire

// >>> tb/testbench.sv
`timescale 1ns/10ps
`default_nettype none

module testbench;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic instr_valid, instr_dest, instr_ptr_sel;
    logic [3:0] instr_op;
    logic [6:0] instr_reg_idx;
    logic [7:0] instr_literal, acc_out;
    logic [2:0] instr_bit;
    logic carry_out, nibble_overflow_bit, zero_out, avs_waitrequest;
    logic [15:0] ptr0_out, ptr1_out;
    logic [9:0] avs_address = 10'h000;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h00000000;
    logic [3:0] avs_byteenable = 4'hf;
    logic [31:0] avs_readdata, rd_seen, got;
    logic wait_seen;
    int mismatches = 0;
    int compares = 0;

    always #2.5 ref_clk = ~ref_clk;
    // Inputs move only just after a rising edge, so the falling edge sees
    // what the next rising edge will sample
    always @(negedge ref_clk) begin
        wait_seen = avs_waitrequest;
        rd_seen = avs_readdata;
    end

    bal_decode_model i_dec (.ref_clk(ref_clk), .instr_valid(instr_valid),
        .instr_op(instr_op), .instr_reg_idx(instr_reg_idx),
        .instr_literal(instr_literal), .instr_dest(instr_dest),
        .instr_bit(instr_bit), .instr_ptr_sel(instr_ptr_sel));

    bal_alu i_dut (.ref_clk(ref_clk), .rst_n(rst_n),
        .instr_valid(instr_valid), .instr_op(instr_op),
        .instr_reg_idx(instr_reg_idx), .instr_literal(instr_literal),
        .instr_dest(instr_dest), .instr_bit(instr_bit),
        .instr_ptr_sel(instr_ptr_sel), .acc_out(acc_out),
        .carry_out(carry_out), .nibble_overflow_bit(nibble_overflow_bit),
        .zero_out(zero_out), .ptr0_out(ptr0_out), .ptr1_out(ptr1_out),
        .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest));

    ////////////////////////////////////////////////////////////////////////
    task automatic give_verdict();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        compares++;
        if (g !== e) begin
            mismatches++;
            $display("BAD t=%0t got %h exp %h", $time, g, e);
        end
    endtask

    // Expected flags as {zero, nibble, carry}
    task automatic chk_flags(input logic [2:0] e);
        chk({29'h0, zero_out, nibble_overflow_bit, carry_out}, {29'h0, e});
    endtask

    task automatic bus_wr(input logic [9:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= 1'b1;
        // Only the watchdog ends a wait that never finishes
        do begin
            @(posedge ref_clk);
        end while (wait_seen);
        avs_write <= 1'b0;
    endtask

    task automatic bus_rd(input logic [9:0] a, output logic [31:0] d);
        @(posedge ref_clk);
        avs_address <= a;
        avs_read <= 1'b1;
        do begin
            @(posedge ref_clk);
        end while (wait_seen);
        d = rd_seen;
        avs_read <= 1'b0;
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic t_ptr();
        bus_wr(10'h004, 32'h7);
        bus_wr(10'h008, 32'h0001);
        bus_wr(10'h00c, 32'hfffe);
        i_dec.issue(4'h1, 7'h00, 8'h20, 1'b0, 3'h0, 1'b0);
        chk({16'h0, ptr0_out}, 32'hffe1);
        i_dec.issue(4'h1, 7'h00, 8'h1f, 1'b0, 3'h0, 1'b1);
        chk({16'h0, ptr1_out}, 32'h001d);
        chk({16'h0, ptr0_out}, 32'hffe1);
        chk_flags(3'h7);
        $display("pointer add done");
    endtask

    task automatic t_imm();
        bus_wr(10'h000, 32'h3c);
        i_dec.issue(4'h2, 7'h00, 8'h0f, 1'b0, 3'h0, 1'b0);
        chk({24'h0, acc_out}, 32'h0c);
        chk_flags(3'h3);
        bus_wr(10'h004, 32'h0);
        i_dec.issue(4'h3, 7'h00, 8'hf4, 1'b0, 3'h0, 1'b0);
        chk({24'h0, acc_out}, 32'h00);
        chk_flags(3'h7);
        $display("immediate ops done");
    endtask

    task automatic t_reg();
        bus_wr(10'h214, 32'h88);
        bus_wr(10'h000, 32'h78);
        i_dec.issue(4'h4, 7'h05, 8'h00, 1'b0, 3'h0, 1'b0);
        chk({24'h0, acc_out}, 32'h08);
        chk_flags(3'h3);
        i_dec.issue(4'h5, 7'h05, 8'h00, 1'b1, 3'h0, 1'b0);
        chk_flags(3'h2);
        bus_rd(10'h214, got);
        chk(got, 32'h90);
        chk({24'h0, acc_out}, 32'h08);
        bus_wr(10'h004, 32'h1);
        i_dec.issue(4'h6, 7'h05, 8'h00, 1'b0, 3'h0, 1'b0);
        chk({24'h0, acc_out}, 32'h99);
        chk_flags(3'h0);
        i_dec.issue(4'h6, 7'h05, 8'h00, 1'b1, 3'h0, 1'b0);
        chk_flags(3'h1);
        bus_rd(10'h214, got);
        chk(got, 32'h29);
        $display("register ops done");
    endtask

    task automatic t_shift();
        bus_wr(10'h21c, 32'h81);
        bus_wr(10'h004, 32'h2);
        i_dec.issue(4'h7, 7'h07, 8'h00, 1'b1, 3'h0, 1'b0);
        bus_rd(10'h21c, got);
        chk(got, 32'hc0);
        chk_flags(3'h3);
        bus_wr(10'h21c, 32'h01);
        i_dec.issue(4'h7, 7'h07, 8'h00, 1'b0, 3'h0, 1'b0);
        chk({24'h0, acc_out}, 32'h00);
        chk_flags(3'h7);
        $display("shift done");
    endtask

    task automatic t_clr();
        logic [7:0] e;
        e = 8'hff;
        bus_wr(10'h224, 32'hff);
        bus_wr(10'h004, 32'h5);
        for (int b = 0; b < 8; b++) begin
            i_dec.issue(4'h8, 7'h09, 8'h00, 1'b0, 3'(b), 1'b0);
            e[b] = 1'b0;
            bus_rd(10'h224, got);
            chk(got, {24'h0, e});
            chk_flags(3'h5);
        end
        // Unmapped place reads as zero
        bus_rd(10'h010, got);
        chk(got, 32'h0);
        $display("clear bit done");
    endtask

    // A bus write meeting an instruction must wait and land after it
    task automatic t_stall();
        fork
            i_dec.issue(4'h3, 7'h00, 8'h01, 1'b0, 3'h0, 1'b0);
            bus_wr(10'h000, 32'h5a);
            begin
                @(posedge ref_clk);
                @(negedge ref_clk);
                chk({31'h0, avs_waitrequest}, 32'h1);
            end
        join
        @(negedge ref_clk);
        chk({24'h0, acc_out}, 32'h5a);
        chk_flags(3'h0);
        $display("bus stall done");
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        #20000;
        mismatches++;
        give_verdict();
    end

    initial begin
        repeat (5) @(posedge ref_clk);
        rst_n <= 1'b1;
        t_ptr();
        t_imm();
        t_reg();
        t_shift();
        t_clr();
        t_stall();
        give_verdict();
    end
endmodule // testbench

`default_nettype wire
